// file: rtl/reg_bits_pkg.sv
package reg_bits_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned ADDR_W      = 3;
    localparam int unsigned STAT_W      = 4;
    localparam int unsigned PULSE_W     = 4;

    localparam logic [15:0] RST_CTRL    = 16'h0000;
    localparam logic [15:0] RST_WO      = 16'h0000;
    localparam logic [15:0] RST_W1C     = 16'h0000;
    localparam logic [15:0] RST_RDCLR   = 16'h0000;
    localparam logic [15:0] RST_SELFCLR = 16'h0000;
    localparam logic [15:0] RST_LATCH   = 16'h0000;
    localparam logic [15:0] READ_WO_VAL = 16'h0000;

    // ------------------------------------------------------------
    // Word indices on the management port
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_CTRL    = 3'h0;
    localparam logic [2:0] IDX_RO      = 3'h1;
    localparam logic [2:0] IDX_RDCLR   = 3'h2;
    localparam logic [2:0] IDX_WO      = 3'h3;
    localparam logic [2:0] IDX_W1C     = 3'h4;
    localparam logic [2:0] IDX_LATCH   = 3'h5;
    localparam logic [2:0] IDX_SELFCLR = 3'h6;

    // Latch word layout: low nibble latched low, next latched high
    localparam int unsigned LOW_LSB    = 0;
    localparam int unsigned HIGH_LSB   = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [2:0]        addr;
        logic [15:0]       wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic              valid;
        logic [15:0]       rdata;
    } mgmt_rsp_t;

    typedef enum logic [1:0] {
        LATCH_FREE,
        LATCH_HELD
    } latch_state_t;

endpackage

// file: rtl/latch_status_bit.sv
`timescale 1ns/100ps
module latch_status_bit
#(
    parameter bit HOLD_HIGH = 1'b0
)
(
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic sys_rst_in,
    // Condition and host read
    input  wire logic cond_in,
    input  wire logic read_in,
    // Status
    output logic      status_out
);
    reg_bits_pkg::latch_state_t state_q;
    reg_bits_pkg::latch_state_t state_d;
    logic                       status_q;
    logic                       status_d;
    logic                       hit;

    assign hit        = HOLD_HIGH ? cond_in : ~cond_in;
    assign status_out = status_q;

    always_comb
    begin
        state_d  = state_q;
        status_d = status_q;
        case (state_q)
            reg_bits_pkg::LATCH_FREE:
            begin
                status_d = cond_in;
                if (hit)
                begin
                    state_d = reg_bits_pkg::LATCH_HELD;
                end
            end
            reg_bits_pkg::LATCH_HELD:
            begin
                status_d = HOLD_HIGH;
                if (read_in && !hit)
                begin
                    state_d  = reg_bits_pkg::LATCH_FREE;
                    status_d = cond_in;
                end
            end
            default:
            begin
                state_d  = reg_bits_pkg::LATCH_FREE;
                status_d = cond_in;
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_q  <= reg_bits_pkg::LATCH_FREE;
            status_q <= HOLD_HIGH ? 1'b0 : 1'b1;
        end
        else
        begin
            state_q  <= state_d;
            status_q <= status_d;
        end
    end
endmodule // latch_status_bit

// file: rtl/reg_bit_bank.sv
// Notes on behaviour
// - A read-only word returns its live value and ignores every write.
// - A read-clear word returns its value and is then zero; writes do nothing.
// - A write-only word takes writes and reads back READ_WO_VAL (zero).
// - A write-one-clear bit clears where a one is written, else keeps state.
// - A latched-low status bit stays low until read, even if the cause goes.
// - Reading a latched-low bit whose cause has gone releases it to follow its live condition.
// - A latched-high status bit stays high until read; a read after the cause has gone releases it.
// - A self-clearing bit set by the host clears once its action is taken.
`timescale 1ns/100ps
module reg_bit_bank
(
    // Clock and reset
    input  wire logic                     clock_in,
    input  wire logic                     sys_rst_in,
    // Management port
    input  wire reg_bits_pkg::mgmt_req_t  req_in,
    output reg_bits_pkg::mgmt_rsp_t       rsp_out,
    // Hardware side
    input  wire logic [15:0]              ro_value_in,
    input  wire logic [15:0]              event_in,
    input  wire logic [15:0]              count_event_in,
    input  wire logic [3:0]               low_cond_in,
    input  wire logic [3:0]               high_cond_in,
    input  wire logic [3:0]               action_done_in,
    output logic [15:0]                   ctrl_out,
    output logic [15:0]                   wo_out,
    output logic [3:0]                    action_out
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0]             ctrl_q;
    logic [15:0]             ctrl_d;
    logic [15:0]             wo_q;
    logic [15:0]             wo_d;
    logic [15:0]             w1c_q;
    logic [15:0]             w1c_d;
    logic [15:0]             rdclr_q;
    logic [15:0]             rdclr_d;
    logic [3:0]              selfclr_q;
    logic [3:0]              selfclr_d;
    reg_bits_pkg::mgmt_rsp_t rsp_q;
    reg_bits_pkg::mgmt_rsp_t rsp_d;
    logic [3:0]              low_stat;
    logic [3:0]              high_stat;
    logic                    rd_latch;
    logic                    rd_clr;

    function automatic logic hit(input reg_bits_pkg::mgmt_req_t r,
                                 input logic [2:0] idx, input logic rd);
        hit = (rd ? r.rd : r.wr) && (r.addr == idx);
    endfunction

    assign rd_latch = hit(req_in, reg_bits_pkg::IDX_LATCH, 1'b1);
    assign rd_clr   = hit(req_in, reg_bits_pkg::IDX_RDCLR, 1'b1);

    // ------------------------------------------------------------
    // Latched status bits
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_latch
            latch_status_bit #(.HOLD_HIGH(1'b0)) u_low
            (
                .clock_in   (clock_in),
                .sys_rst_in (sys_rst_in),
                .cond_in    (low_cond_in[g]),
                .read_in    (rd_latch),
                .status_out (low_stat[g])
            );
            latch_status_bit #(.HOLD_HIGH(1'b1)) u_high
            (
                .clock_in   (clock_in),
                .sys_rst_in (sys_rst_in),
                .cond_in    (high_cond_in[g]),
                .read_in    (rd_latch),
                .status_out (high_stat[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Control and write-only words
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_d = ctrl_q;
        wo_d   = wo_q;
        if (hit(req_in, reg_bits_pkg::IDX_CTRL, 1'b0))
        begin
            ctrl_d = req_in.wdata;
        end
        if (hit(req_in, reg_bits_pkg::IDX_WO, 1'b0))
        begin
            wo_d = req_in.wdata;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_q <= reg_bits_pkg::RST_CTRL;
            wo_q   <= reg_bits_pkg::RST_WO;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            wo_q   <= wo_d;
        end
    end

    // ------------------------------------------------------------
    // Event words: write-one-clear and read-clear
    // ------------------------------------------------------------
    always_comb
    begin
        w1c_d   = w1c_q;
        rdclr_d = rdclr_q;
        if (hit(req_in, reg_bits_pkg::IDX_W1C, 1'b0))
        begin
            w1c_d = w1c_q & ~req_in.wdata;
        end
        // A new event wins over a clear in the same cycle
        w1c_d = w1c_d | event_in;
        if (rd_clr)
        begin
            rdclr_d = 16'h0000;
        end
        rdclr_d = rdclr_d | count_event_in;
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            w1c_q   <= reg_bits_pkg::RST_W1C;
            rdclr_q <= reg_bits_pkg::RST_RDCLR;
        end
        else
        begin
            w1c_q   <= w1c_d;
            rdclr_q <= rdclr_d;
        end
    end

    // ------------------------------------------------------------
    // Self-clearing bits
    // ------------------------------------------------------------
    always_comb
    begin
        selfclr_d = selfclr_q & ~action_done_in;
        if (hit(req_in, reg_bits_pkg::IDX_SELFCLR, 1'b0))
        begin
            // A host set wins over a finished action
            selfclr_d = selfclr_d | req_in.wdata[3:0];
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            selfclr_q <= reg_bits_pkg::RST_SELFCLR[3:0];
        end
        else
        begin
            selfclr_q <= selfclr_d;
        end
    end

    // ------------------------------------------------------------
    // Read response
    // ------------------------------------------------------------
    always_comb
    begin
        rsp_d       = '0;
        rsp_d.valid = req_in.rd;
        if (req_in.rd)
        begin
            case (req_in.addr)
                reg_bits_pkg::IDX_CTRL:    rsp_d.rdata = ctrl_q;
                reg_bits_pkg::IDX_RO:      rsp_d.rdata = ro_value_in;
                reg_bits_pkg::IDX_RDCLR:   rsp_d.rdata = rdclr_q;
                reg_bits_pkg::IDX_WO:
                begin
                    rsp_d.rdata = reg_bits_pkg::READ_WO_VAL;
                end
                reg_bits_pkg::IDX_W1C:     rsp_d.rdata = w1c_q;
                reg_bits_pkg::IDX_LATCH:
                begin
                    rsp_d.rdata[reg_bits_pkg::LOW_LSB +: 4]  = low_stat;
                    rsp_d.rdata[reg_bits_pkg::HIGH_LSB +: 4] = high_stat;
                end
                reg_bits_pkg::IDX_SELFCLR: rsp_d.rdata = {12'h000, selfclr_q};
                default:                   rsp_d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q <= rsp_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rsp_out    = rsp_q;
    assign ctrl_out   = ctrl_q;
    assign wo_out     = wo_q;
    assign action_out = selfclr_q;
endmodule // reg_bit_bank

// file: verification/reg_bit_bank_chk.sv
`timescale 1ns/100ps
module reg_bit_bank_chk
(
    // Clock and reset
    input wire logic                    clock_in,
    input wire logic                    sys_rst_in,
    // Management port
    input wire reg_bits_pkg::mgmt_req_t req_in,
    input wire reg_bits_pkg::mgmt_rsp_t rsp_out,
    // Hardware side
    input wire logic [15:0]             ro_value_in,
    input wire logic [15:0]             event_in,
    input wire logic [15:0]             count_event_in,
    input wire logic [3:0]              low_cond_in,
    input wire logic [3:0]              high_cond_in,
    input wire logic [3:0]              action_done_in,
    input wire logic [3:0]              action_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence rd_at(logic [2:0] a);
        req_in.rd && req_in.addr == a;
    endsequence

    read_answer_a: assert property (req_in.rd |=> rsp_out.valid)
        else $error("read not answered");
    ro_read_a: assert property (rd_at(reg_bits_pkg::IDX_RO)
        |=> rsp_out.rdata == $past(ro_value_in)) else $error("ro value");
    rdclr_zero_a: assert property (rd_at(reg_bits_pkg::IDX_RDCLR)
        ##0 count_event_in == 16'h0 ##1 count_event_in == 16'h0
        ##1 rd_at(reg_bits_pkg::IDX_RDCLR) |=> rsp_out.rdata == 16'h0)
        else $error("read clear kept value");
    wo_read_a: assert property (rd_at(reg_bits_pkg::IDX_WO)
        |=> rsp_out.rdata == reg_bits_pkg::READ_WO_VAL) else $error("wo");
    w1c_clear_a: assert property (req_in.wr && event_in == 16'h0
        && req_in.addr == reg_bits_pkg::IDX_W1C && req_in.wdata == 16'hffff
        ##1 event_in == 16'h0 ##1 rd_at(reg_bits_pkg::IDX_W1C)
        |=> rsp_out.rdata == 16'h0)
        else $error("w1c not cleared");
    low_hold_a: assert property (!low_cond_in[0] && !req_in.rd
        ##1 !req_in.rd ##1 rd_at(reg_bits_pkg::IDX_LATCH)
        |=> !rsp_out.rdata[0]) else $error("low latch lost");
    low_free_a: assert property (rd_at(reg_bits_pkg::IDX_LATCH)
        ##0 low_cond_in[0] ##1 low_cond_in[0]
        ##1 rd_at(reg_bits_pkg::IDX_LATCH) ##0 low_cond_in[0]
        |=> rsp_out.rdata[0]) else $error("low latch stuck");
    high_hold_a: assert property (high_cond_in[0] && !req_in.rd
        ##1 !req_in.rd ##1 rd_at(reg_bits_pkg::IDX_LATCH)
        |=> rsp_out.rdata[4]) else $error("high latch lost");
    self_clear_a: assert property (action_out[0] && action_done_in[0]
        && !req_in.wr |=> !action_out[0]) else $error("self clear stuck");
endmodule // reg_bit_bank_chk

bind reg_bit_bank reg_bit_bank_chk reg_bit_bank_chk_i (.clock_in,
    .sys_rst_in, .req_in, .rsp_out, .ro_value_in, .event_in,
    .count_event_in, .low_cond_in, .high_cond_in, .action_done_in,
    .action_out);

// file: verification/host_model.sv
`timescale 1ns/100ps
module host_model
(
    // Clock
    input wire logic                    clock_in,
    // Management port
    output reg_bits_pkg::mgmt_req_t     req_out,
    input wire reg_bits_pkg::mgmt_rsp_t rsp_in
);
    initial req_out = '0;

    // Called just after a falling edge; request stands over one rising
    // edge, then the bus idles one cycle so no two calls touch one step
    task automatic write_word(input logic [2:0] a, input logic [15:0] d);
        req_out = '{rd: 1'b0, wr: 1'b1, addr: a,
                    wdata: (a == 3'h7) ? 16'h0000 : d};
        @(negedge clock_in);
        req_out = '0;
        @(negedge clock_in);
    endtask

    // Answer stands only in the cycle after the taken edge
    task automatic read_word(input logic [2:0] a, output logic [15:0] d);
        req_out = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge clock_in);
        d = rsp_in.valid ? rsp_in.rdata : 16'hxxxx;
        req_out = '0;
        @(negedge clock_in);
    endtask
endmodule // host_model

// file: verification/tb_register_bit_access_semantics.sv
`timescale 1ns/100ps
`define CHK(got, exp) \
    compares++; \
    if ((got) !== (exp)) \
    begin \
        miscompares++; \
        $display("ERROR %0t got %h exp %h", $time, got, exp); \
    end
module tb_register_bit_access_semantics;
    logic                    clock_in = 1'b0;
    logic                    sys_rst_in = 1'b1;
    reg_bits_pkg::mgmt_req_t req;
    reg_bits_pkg::mgmt_rsp_t rsp;
    logic [15:0]             ro_value = 16'h0;
    logic [15:0]             ev = 16'h0;
    logic [15:0]             cnt = 16'h0;
    logic [3:0]              low = 4'hf;
    logic [3:0]              high = 4'h0;
    logic [3:0]              done = 4'h0;
    logic [15:0]             wo;
    logic [15:0]             ctrl;
    logic [3:0]              action;
    logic [15:0]             d;
    int                      miscompares = 0;
    int                      compares = 0;

    always #20 clock_in = ~clock_in;

    reg_bit_bank reg_bit_bank_i (.clock_in, .sys_rst_in, .req_in(req),
        .rsp_out(rsp), .ro_value_in(ro_value), .event_in(ev),
        .count_event_in(cnt), .low_cond_in(low), .high_cond_in(high),
        .action_done_in(done), .ctrl_out(ctrl), .wo_out(wo),
        .action_out(action));
    host_model host_model_i (.clock_in, .req_out(req), .rsp_in(rsp));

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_read_only();
        ro_value = 16'ha5c3;
        host_model_i.write_word(reg_bits_pkg::IDX_RO, 16'hffff);
        host_model_i.read_word(reg_bits_pkg::IDX_RO, d);
        `CHK(d, 16'ha5c3)
    endtask

    task automatic t_read_clear();
        cnt = 16'h0081;
        @(negedge clock_in);
        cnt = 16'h0;
        host_model_i.write_word(reg_bits_pkg::IDX_RDCLR, 16'hffff);
        host_model_i.read_word(reg_bits_pkg::IDX_RDCLR, d);
        `CHK(d, 16'h0081)
        host_model_i.read_word(reg_bits_pkg::IDX_RDCLR, d);
        `CHK(d, 16'h0000)
    endtask

    task automatic t_write_only();
        host_model_i.write_word(reg_bits_pkg::IDX_WO, 16'h3c5a);
        `CHK(wo, 16'h3c5a)
        host_model_i.read_word(reg_bits_pkg::IDX_WO, d);
        `CHK(d, reg_bits_pkg::READ_WO_VAL)
    endtask

    task automatic t_write_one_clear();
        ev = 16'h00f0;
        @(negedge clock_in);
        ev = 16'h0;
        host_model_i.write_word(reg_bits_pkg::IDX_W1C, 16'h0030);
        host_model_i.read_word(reg_bits_pkg::IDX_W1C, d);
        `CHK(d, 16'h00c0)
        host_model_i.write_word(reg_bits_pkg::IDX_W1C, 16'hffff);
        host_model_i.read_word(reg_bits_pkg::IDX_W1C, d);
        `CHK(d, 16'h0000)
    endtask

    // Upper byte of the latch word is reserved and not compared
    task automatic t_latches();
        low = 4'he;
        high = 4'h1;
        @(negedge clock_in);
        low = 4'hf;
        high = 4'h0;
        @(negedge clock_in);
        host_model_i.read_word(reg_bits_pkg::IDX_LATCH, d);
        `CHK(d[7:0], 8'h1e)
        host_model_i.read_word(reg_bits_pkg::IDX_LATCH, d);
        `CHK(d[7:0], 8'h0f)
    endtask

    // Reading another word leaves a held latch alone
    task automatic t_read_scope();
        host_model_i.write_word(reg_bits_pkg::IDX_CTRL, 16'h1234);
        `CHK(ctrl, 16'h1234)
        low = 4'hd;
        @(negedge clock_in);
        low = 4'hf;
        host_model_i.read_word(reg_bits_pkg::IDX_CTRL, d);
        `CHK(d, 16'h1234)
        host_model_i.read_word(reg_bits_pkg::IDX_LATCH, d);
        `CHK(d[3:0], 4'hd)
    endtask

    task automatic t_self_clear();
        host_model_i.write_word(reg_bits_pkg::IDX_SELFCLR, 16'h0005);
        `CHK(action, 4'h5)
        host_model_i.write_word(reg_bits_pkg::IDX_SELFCLR, 16'h0000);
        host_model_i.read_word(reg_bits_pkg::IDX_SELFCLR, d);
        `CHK(d[3:0], 4'h5)
        done = 4'h1;
        @(negedge clock_in);
        done = 4'h0;
        `CHK(action, 4'h4)
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #40000;
        miscompares++;
        stop_test();
    end

    initial
    begin
        repeat (2) @(negedge clock_in);
        sys_rst_in = 1'b0;
        t_read_only();
        t_read_clear();
        t_write_only();
        t_write_one_clear();
        t_latches();
        t_read_scope();
        t_self_clear();
        stop_test();
    end
endmodule // tb_register_bit_access_semantics
